// file: relay_pulse_status_msg.sv
// Purpose: Relay output sequencer and per-input status message framer.
// Assumes: Inputs are asynchronous pins; config and commands are on clk.
// Notes: Messages stream out one byte per accepted beat, no reply expected.
`default_nettype none
module relay_pulse_status_msg #(
	parameter int unsigned TICK_CYCLES = relay_pkg::TICK_CYCLES,
	parameter int unsigned SESSIONS = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire relay_pkg::out_cfg_t cfg, // Output channel configuration.
	input wire logic [2:0] bind_src, // Input index (0-6) bound to the output.
	input wire logic bind_en, // Follow the bound input instead of commands.
	input wire logic cmd_activate, // One-cycle manual activate/start.
	input wire logic cmd_deactivate, // One-cycle manual deactivate/stop.
	input wire logic failsafe_fire, // One-cycle failsafe timer event.
	input wire relay_pkg::in_state_t in_pins, // Raw input levels and alarms.
	input wire logic [SESSIONS-1:0] session_assoc, // Sessions tied to any input.
	input wire logic [47:0] hw_addr, // Sender hardware network address.
	output logic relay_out, // Channel drive, high is active.
	output logic busy, // Sequencer is timing a phase.
	output logic [7:0] msg_data, // Message byte.
	output logic msg_valid, // Byte is valid.
	input wire logic msg_ready, // Sink takes the byte.
	output logic msg_last, // Last byte of a 20-byte message.
	output logic [SESSIONS-1:0] msg_sessions // Sessions that receive it.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Refuse, at elaboration, a tick of fewer than two clocks or no sessions at all:
	// the prescaler could never count a whole unit, and the mask would have no bits.
	if (TICK_CYCLES < 2 || SESSIONS < 1) begin : bad_params
		$error("Unsupported parameter value.");
	end

	// Clamp a width into the legal range of 1 to 9999 units.
	function automatic logic [13:0] clamp_width(input logic [13:0] w);
		if (w < relay_pkg::WIDTH_MIN) begin
			return relay_pkg::WIDTH_MIN;
		end else if (w > relay_pkg::WIDTH_MAX) begin
			return relay_pkg::WIDTH_MAX;
		end
		return w;
	endfunction

	// Prescaler state that produces the 100 ms tick.
	logic [31:0] pre_cnt;
	logic [31:0] next_pre_cnt;
	logic tick;
	logic restart; // An activate command also realigns the prescaler.

	// Prescaler: one-cycle tick every TICK_CYCLES clocks.
	// A start realigns it, so the first unit of a phase is a whole one, never a stub.
	always_comb begin
		tick = (pre_cnt == TICK_CYCLES - 1);
		if (tick || restart) begin
			next_pre_cnt = '0;
		end else begin
			next_pre_cnt = pre_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
		end
	end

	// Two-flop synchroniser for the input pins.
	// Only the second stage is read, so a metastable first stage never reaches logic.
	relay_pkg::in_state_t sync_a;
	relay_pkg::in_state_t sync_b;
	relay_pkg::in_state_t seen; // Last reported state.

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= in_pins;
			sync_b <= sync_a;
		end
	end

	// Sequencer states.
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ON_PHASE,
		SEQ_OFF_PHASE,
		SEQ_DELAY
	} seq_t;
	seq_t seq;
	seq_t next_seq;
	logic [13:0] phase_cnt;
	logic [13:0] next_phase_cnt;
	logic [15:0] pulses_left;
	logic [15:0] next_pulses_left;
	logic next_relay_out;

	// Sequencer: manual, pulse, delayed on and delayed off behaviour.
	always_comb begin
		next_seq = seq;
		next_phase_cnt = phase_cnt;
		next_pulses_left = pulses_left;
		next_relay_out = relay_out;
		restart = 1'b0;
		if (bind_en) begin
			// A bound output follows exactly one selected input.
			next_seq = SEQ_IDLE;
			// An index past the last source reads as inactive, never as unknown.
			if (bind_src < 3'(relay_pkg::NUM_SOURCES)) begin
				next_relay_out = sync_b.level[bind_src];
			end else begin
				next_relay_out = 1'b0;
			end
		end else if (cmd_deactivate) begin
			// Manual stop ends any timing and drops the output.
			next_seq = SEQ_IDLE;
			next_relay_out = 1'b0;
		end else if (cmd_activate) begin
			restart = 1'b1;
			unique case (cfg.mode)
				relay_pkg::MODE_MANUAL: begin
					// Manual drive applies no timing, so any running phase is dropped.
					next_seq = SEQ_IDLE;
					next_relay_out = 1'b1;
				end
				relay_pkg::MODE_PULSE: begin
					// Start with an active phase.
					next_seq = SEQ_ON_PHASE;
					next_relay_out = 1'b1;
					next_phase_cnt = clamp_width(cfg.active_width);
					if (cfg.pulse_count == '0) begin
						next_pulses_left = relay_pkg::COUNT_DEFAULT;
					end else begin
						next_pulses_left = cfg.pulse_count;
					end
				end
				relay_pkg::MODE_DELAY_ON: begin
					next_seq = SEQ_DELAY;
					next_relay_out = 1'b0;
					next_phase_cnt = clamp_width(cfg.delay_width);
				end
				relay_pkg::MODE_DELAY_OFF: begin
					next_seq = SEQ_DELAY;
					next_relay_out = 1'b1;
					next_phase_cnt = clamp_width(cfg.delay_width);
				end
			endcase
		end else if (failsafe_fire && cfg.fs_action != relay_pkg::FS_NONE) begin
			// Failsafe forces a level and stops timing.
			next_seq = SEQ_IDLE;
			next_relay_out = (cfg.fs_action == relay_pkg::FS_ACTIVATE);
		end else if (tick && seq != SEQ_IDLE) begin
			if (phase_cnt > 14'h0001) begin
				next_phase_cnt = phase_cnt - 14'h0001;
			end else begin
				unique case (seq)
					SEQ_ON_PHASE: begin
						next_seq = SEQ_OFF_PHASE;
						next_relay_out = 1'b0;
						next_phase_cnt = clamp_width(cfg.inactive_width);
					end
					SEQ_OFF_PHASE: begin
						if (cfg.counted && pulses_left <= 16'h0001) begin
							next_seq = SEQ_IDLE;
						end else begin
							// Continuous repeats forever; counted uses one pulse.
							if (cfg.counted) begin
								next_pulses_left = pulses_left - 16'h0001;
							end
							next_seq = SEQ_ON_PHASE;
							next_relay_out = 1'b1;
							next_phase_cnt = clamp_width(cfg.active_width);
						end
					end
					SEQ_DELAY: begin
						next_seq = SEQ_IDLE;
						// Delayed on drives active; delayed off drives inactive.
						next_relay_out = (cfg.mode == relay_pkg::MODE_DELAY_ON);
					end
					default: begin
						next_seq = SEQ_IDLE;
					end
				endcase
			end
		end
	end

	// Registers of the sequencer; reset leaves the channel inactive and idle.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq <= SEQ_IDLE;
			phase_cnt <= relay_pkg::WIDTH_DEFAULT;
			pulses_left <= relay_pkg::COUNT_DEFAULT;
			relay_out <= 1'b0;
		end else begin
			seq <= next_seq;
			phase_cnt <= next_phase_cnt;
			pulses_left <= next_pulses_left;
			relay_out <= next_relay_out;
		end
	end

	// Busy is high whenever a phase or a delay is being timed.
	assign busy = (seq != SEQ_IDLE);

	// Framer state.
	logic sending;
	logic next_sending;
	logic [4:0] byte_idx;
	logic [4:0] next_byte_idx;
	logic [2:0] src;
	logic [2:0] next_src;
	relay_pkg::in_state_t next_seen;
	logic [7:0] next_msg_data;
	logic [SESSIONS-1:0] next_msg_sessions;
	logic [2:0] pick;
	logic found;

	// Build one message byte for source s at index i.
	function automatic logic [7:0] msg_byte(input logic [4:0] i, input logic [2:0] s,
			input relay_pkg::in_state_t st, input logic [47:0] addr);
		logic [7:0] b;
		b = relay_pkg::BYTE_ZERO;
		unique case (i)
			5'h00: b = (s < 3'(relay_pkg::NUM_DIGITAL)) ? relay_pkg::TYPE_DIGITAL
				: relay_pkg::TYPE_SERIAL;
			5'h01: b = 8'({5'h00, s} + 8'h01);
			5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07:
				b = addr[8'(47 - 8 * (i - 5'h02)) -: 8];
			5'h08: b = st.alarm[s] ? relay_pkg::BYTE_ONE : relay_pkg::BYTE_ZERO;
			5'h09: b = st.level[s] ? relay_pkg::BYTE_ONE : relay_pkg::BYTE_ZERO;
			default: b = relay_pkg::BYTE_ZERO;
		endcase
		return b;
	endfunction

	// Framer: pick the lowest changed input and stream its 20 bytes.
	// Only level changes start a message; an alarm change alone is carried by the next one.
	// Changes that arrive during a message wait, since seen keeps their old level.
	always_comb begin
		next_sending = sending;
		next_byte_idx = byte_idx;
		next_src = src;
		next_seen = seen;
		next_msg_data = msg_data;
		next_msg_sessions = msg_sessions;
		pick = '0;
		found = 1'b0;
		for (int k = relay_pkg::NUM_SOURCES - 1; k >= 0; k--) begin
			if (sync_b.level[k] != seen.level[k]) begin
				pick = 3'(k);
				found = 1'b1;
			end
		end
		if (!sending) begin
			if (found && session_assoc != '0) begin
				// Capture only this input; others wait for their own message.
				next_sending = 1'b1;
				next_src = pick;
				next_byte_idx = '0;
				next_seen.level[pick] = sync_b.level[pick];
				next_seen.alarm[pick] = sync_b.alarm[pick];
				next_msg_data = msg_byte(5'h00, pick, sync_b, hw_addr);
				next_msg_sessions = session_assoc;
			end else if (found) begin
				// No session listens; record the change and move on.
				next_seen.level[pick] = sync_b.level[pick];
			end
		end else if (msg_ready) begin
			if (byte_idx == 5'(relay_pkg::MSG_BYTES - 1)) begin
				next_sending = 1'b0;
			end else begin
				next_byte_idx = byte_idx + 5'h01;
				next_msg_data = msg_byte(byte_idx + 5'h01, src, seen, hw_addr);
			end
		end
	end

	// Registers of the framer; the snapshot in seen feeds the later bytes.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sending <= 1'b0;
			byte_idx <= '0;
			src <= '0;
			seen <= '0;
			msg_data <= '0;
			msg_sessions <= '0;
		end else begin
			sending <= next_sending;
			byte_idx <= next_byte_idx;
			src <= next_src;
			seen <= next_seen;
			msg_data <= next_msg_data;
			msg_sessions <= next_msg_sessions;
		end
	end

	// Valid stands for the whole message; the sink paces it with ready alone.
	// Last marks the final reserved byte, so a receiver can resync on 20-byte blocks.
	assign msg_valid = sending;
	assign msg_last = sending && (byte_idx == 5'(relay_pkg::MSG_BYTES - 1));
endmodule
`default_nettype wire

// file: relay_pkg.sv
// Purpose: Shared constants and types for the relay sequencer and status framer.
// Assumes: A 200 MHz clock and a 100 ms timing unit.
// Notes: All timing widths are in 100 ms units.
// What this block does
// - Manual mode follows activate and deactivate commands.
// - Pulse mode alternates phases after activation.
// - Inactive-to-active delay holds inactive, then activates.
// - Active-to-inactive delay deactivates after the delay.
// - Pulse offers continuous (default) and counted sub-modes.
// - Counted pulses emit N active/inactive pairs, default 1.
// - Inactive width 1 to 9999 units, default 1.
// - Active width 1 to 9999 units, default 1.
// - Delay 1 to 9999 units, from manual start.
// - Failsafe leaves, forces active, or forces inactive.
// - Input change sends status to every associated session.
// - No response awaited after a status message.
// - Each input reported alone, only on change.
// - Message is 20 bytes, ten used, ten reserved.
// - Fields: type, number, address, alarm, status, reserved.
// - Type is 0 digital, 1 serial line.
// - Number 1-4 digital, 5 DSR, 6 DCD, 7 CTS.
// - Status byte is 0 inactive, 1 active.
// - Reserved bytes are sent as zero.
// - Each output bound to at most one input.
`default_nettype none
package relay_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	// Clock rate and tick period.
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_MS = 100;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	// Programmable width limits and defaults.
	localparam logic [13:0] WIDTH_MIN = 14'h0001;
	localparam logic [13:0] WIDTH_MAX = 14'h270F;
	localparam logic [13:0] WIDTH_DEFAULT = 14'h0001;
	localparam logic [15:0] COUNT_DEFAULT = 16'h0001;
	// Message layout.
	localparam int unsigned MSG_BYTES = 20;
	localparam int unsigned MSG_USED = 10;
	localparam logic [7:0] TYPE_DIGITAL = 8'h00;
	localparam logic [7:0] TYPE_SERIAL = 8'h01;
	localparam logic [7:0] NUM_DSR = 8'h05;
	localparam logic [7:0] NUM_DCD = 8'h06;
	localparam logic [7:0] NUM_CTS = 8'h07;
	localparam int unsigned NUM_DIGITAL = 4;
	localparam int unsigned NUM_SOURCES = 7;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	// Output modes; manual is the reset choice.
	typedef enum logic [1:0] {
		MODE_MANUAL,
		MODE_PULSE,
		MODE_DELAY_ON,
		MODE_DELAY_OFF
	} out_mode_t;
	// Failsafe actions; none is the reset choice.
	typedef enum logic [1:0] {
		FS_NONE,
		FS_ACTIVATE,
		FS_DEACTIVATE
	} fs_action_t;
	// Output channel configuration.
	typedef struct packed {
		out_mode_t mode;
		logic counted;
		logic [15:0] pulse_count;
		logic [13:0] inactive_width;
		logic [13:0] active_width;
		logic [13:0] delay_width;
		fs_action_t fs_action;
	} out_cfg_t;
	// One input status sample from the input logic.
	typedef struct packed {
		logic [NUM_SOURCES-1:0] level;
		logic [NUM_SOURCES-1:0] alarm;
	} in_state_t;
endpackage
`default_nettype wire

// file: relay_pulse_status_msg_checker.sv
// Purpose: Port-level checks of the relay sequencer and status framer.
// Assumes: Tick period of at least three clocks.
// Notes: Bound onto the top module below.
`default_nettype none
module relay_pulse_status_msg_checker #(
	parameter int unsigned SESSIONS = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire relay_pkg::out_cfg_t cfg,
	input wire logic bind_en,
	input wire logic cmd_activate,
	input wire logic cmd_deactivate,
	input wire logic failsafe_fire,
	input wire logic relay_out,
	input wire logic [7:0] msg_data,
	input wire logic msg_valid,
	input wire logic msg_ready,
	input wire logic msg_last,
	input wire logic [SESSIONS-1:0] msg_sessions
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic free; // No command competes with the failsafe event.
	logic [4:0] beat; // Index of the byte now offered.
	assign free = !bind_en && !cmd_activate && !cmd_deactivate;
	// Counts accepted bytes so the frame length can be judged.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			beat <= 5'h00;
		end else if (msg_valid && msg_ready) begin
			beat <= msg_last ? 5'h00 : beat + 5'h01;
		end
	end
	stop_drops_a: assert property (cmd_deactivate && !bind_en |=> !relay_out)
		else $error("output still on after stop");
	start_raises_a: assert property (cmd_activate && !cmd_deactivate && !bind_en
		&& cfg.mode != relay_pkg::MODE_DELAY_ON |=> relay_out) else $error("no start");
	delay_holds_a: assert property (cmd_activate && !cmd_deactivate && !bind_en
		&& cfg.mode == relay_pkg::MODE_DELAY_ON |=> !relay_out [*3]) else $error("early on");
	fs_on_a: assert property (failsafe_fire && free
		&& cfg.fs_action == relay_pkg::FS_ACTIVATE |=> relay_out) else $error("fs on");
	fs_off_a: assert property (failsafe_fire && free
		&& cfg.fs_action == relay_pkg::FS_DEACTIVATE |=> !relay_out) else $error("fs off");
	fs_none_a: assert property (failsafe_fire && free && cfg.fs_action == relay_pkg::FS_NONE
		&& cfg.mode == relay_pkg::MODE_MANUAL |=> $stable(relay_out)) else $error("fs none");
	byte_hold_a: assert property (msg_valid && !msg_ready
		|=> msg_valid && $stable(msg_data) && $stable(msg_last)) else $error("byte dropped");
	frame_end_a: assert property (msg_valid && msg_ready && msg_last |=> !msg_valid)
		else $error("valid after last");
	twenty_bytes_a: assert property (msg_valid && msg_last |-> beat == 5'h13)
		else $error("frame length");
	reserved_zero_a: assert property (msg_valid && msg_last |-> msg_data == 8'h00)
		else $error("reserved not zero");
	type_first_a: assert property ($rose(msg_valid) |-> msg_data <= 8'h01
		&& msg_sessions != '0) else $error("bad type or sessions");
endmodule
bind relay_pulse_status_msg relay_pulse_status_msg_checker #(.SESSIONS(SESSIONS)) chk (
	.clk, .sys_rst, .cfg, .bind_en, .cmd_activate, .cmd_deactivate, .failsafe_fire,
	.relay_out, .msg_data, .msg_valid, .msg_ready, .msg_last, .msg_sessions
);
`default_nettype wire

// file: msg_sink.sv
// Purpose: Receiving application that takes status messages.
// Assumes: Messages are 20 bytes with msg_last on the final one.
// Notes: Stalls every other cycle when slow is high.
`default_nettype none
module msg_sink (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic slow, // Stall on alternate cycles.
	input wire logic msg_valid,
	input wire logic [7:0] msg_data,
	input wire logic msg_last,
	input wire logic [3:0] msg_sessions,
	output logic msg_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] bytes_seen [20]; // Bytes of the latest message.
	logic [3:0] sess; // Sessions named by the latest message.
	int idx = 0;
	int msg_cnt = 0; // Messages of a known type.
	// Takes one byte per beat and never answers the sender.
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msg_ready <= 1'b0;
			idx <= 0;
		end else begin
			msg_ready <= slow ? ~msg_ready : 1'b1;
			if (msg_valid && msg_ready) begin
				bytes_seen[idx] <= msg_data;
				idx <= msg_last ? 0 : idx + 1;
				// Unknown types are still stored, but are not counted.
				if (msg_last && bytes_seen[0] <= 8'h01) msg_cnt <= msg_cnt + 1;
				if (msg_last) sess <= msg_sessions;
			end
		end
	end
endmodule
`default_nettype wire

// file: relay_pulse_status_msg_test.sv
// Purpose: Self-checking bench of the relay sequencer and framer.
// Assumes: Tick shortened to ten clocks.
// Notes: Inputs change 1 ns after the rising edge.
`default_nettype none
module relay_pulse_status_msg_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 10; // Clocks per tick.
	logic clk = 0;
	logic sys_rst = 1;
	relay_pkg::out_cfg_t cfg;
	logic [2:0] bind_src = 3'h5;
	logic bind_en = 0, cmd_activate = 0, cmd_deactivate = 0, failsafe_fire = 0, slow = 0;
	relay_pkg::in_state_t in_pins = '0;
	logic [3:0] session_assoc = 4'h0;
	logic [47:0] hw_addr = 48'h0a1b_2c3d_4e5f;
	logic relay_out, busy, msg_valid, msg_ready, msg_last;
	logic [7:0] msg_data;
	logic [3:0] msg_sessions;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	relay_pulse_status_msg #(.TICK_CYCLES(T), .SESSIONS(4)) DUT (.clk, .sys_rst, .cfg,
		.bind_src, .bind_en, .cmd_activate, .cmd_deactivate, .failsafe_fire, .in_pins,
		.session_assoc, .hw_addr, .relay_out, .busy, .msg_data, .msg_valid, .msg_ready,
		.msg_last, .msg_sessions);
	msg_sink sink (.clk, .sys_rst, .slow, .msg_valid, .msg_data, .msg_last,
		.msg_sessions, .msg_ready);
	always #2.5 clk = ~clk;
	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			results();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Pulses activate (4), deactivate (2) or failsafe (1) for one cycle.
	// An edge passes first, so two calls never touch a strobe twice in one step.
	task automatic cmd(input logic [2:0] v);
		step(1);
		{cmd_activate, cmd_deactivate, failsafe_fire} = v;
		step(1);
		{cmd_activate, cmd_deactivate, failsafe_fire} = 3'h0;
	endtask
	task automatic t_manual();
		cmd(3'h4);
		step(3 * T);
		check(relay_out, 1);
		cmd(3'h2);
		check(relay_out, 0);
		$display("manual done");
	endtask
	task automatic t_pulse(input logic counted);
		int hi = 0, lo = 0, rises = 0;
		logic prev = 0;
		cfg.mode = relay_pkg::MODE_PULSE;
		cfg.counted = counted;
		cfg.pulse_count = 16'h0002;
		cfg.active_width = 14'h0002;
		cfg.inactive_width = counted ? 14'h0003 : 14'h0001;
		cmd(3'h4);
		repeat (20 * T) begin
			rises += int'(relay_out && !prev);
			hi += int'(relay_out);
			lo += int'(!relay_out && busy);
			prev = relay_out;
			step(1);
		end
		if (counted) begin
			check(rises, 2);
			check((hi + T / 2) / T, 4);
			check((lo + T / 2) / T, 6);
			check(busy, 0);
		end else begin
			check(rises > 5, 1);
			check(busy, 1);
		end
		cmd(3'h2);
		$display("pulse done");
	endtask
	task automatic t_delay();
		cfg.delay_width = 14'h0003;
		cfg.mode = relay_pkg::MODE_DELAY_ON;
		cmd(3'h4);
		step(2 * T);
		check(relay_out, 0);
		step(2 * T);
		check(relay_out, 1);
		cfg.mode = relay_pkg::MODE_DELAY_OFF;
		cmd(3'h4);
		step(2 * T);
		check(relay_out, 1);
		step(2 * T);
		check(relay_out, 0);
		$display("delay done");
	endtask
	task automatic t_fs();
		relay_pkg::fs_action_t acts [4];
		acts = '{relay_pkg::FS_ACTIVATE, relay_pkg::FS_NONE, relay_pkg::FS_DEACTIVATE,
			relay_pkg::FS_NONE};
		cfg.mode = relay_pkg::MODE_MANUAL;
		for (int i = 0; i < 4; i++) begin
			cfg.fs_action = acts[i];
			cmd(3'h1);
			step(1);
			check(relay_out, i < 2);
		end
		$display("failsafe done");
	endtask
	task automatic t_bind();
		int n = sink.msg_cnt;
		bind_en = 1;
		in_pins.level[5] = 1;
		step(5);
		cmd(3'h2);
		check(relay_out, 1);
		in_pins.level[5] = 0;
		step(5);
		check(relay_out, 0);
		check(sink.msg_cnt, n);
		bind_en = 0;
		$display("bind done");
	endtask
	task automatic get_msg(input int i, input logic lvl);
		int n = sink.msg_cnt;
		logic [7:0] e [20];
		e = '{default: 8'h00};
		e[0] = 8'(i > 3);
		e[1] = 8'(i + 1);
		for (int k = 0; k < 6; k++) e[2 + k] = hw_addr[47 - 8 * k -: 8];
		e[8] = 8'(in_pins.alarm[i]);
		e[9] = 8'(lvl);
		for (int k = 0; k < 200 && sink.msg_cnt == n; k++) step(1);
		check(sink.msg_cnt, n + 1);
		for (int k = 0; k < 20; k++) check(sink.bytes_seen[k], e[k]);
		check(sink.sess, session_assoc);
	endtask
	task automatic t_msg();
		session_assoc = 4'h5;
		for (int i = 0; i < 7; i++) begin
			slow = i > 2;
			in_pins.alarm[i] = i[0];
			in_pins.level[i] = 1;
			get_msg(i, 1);
		end
		in_pins.level[1] = 0;
		in_pins.level[4] = 0;
		get_msg(1, 0);
		get_msg(4, 0);
		$display("message done");
	endtask
	initial begin
		cfg = '{relay_pkg::MODE_MANUAL, 1'b0, 16'h0001, 14'h0001, 14'h0001, 14'h0001,
			relay_pkg::FS_NONE};
		step(10);
		sys_rst = 0;
		t_manual();
		t_pulse(1);
		t_pulse(0);
		t_delay();
		t_fs();
		t_bind();
		t_msg();
		results();
	end
endmodule
`default_nettype wire
